// >>> rtl/acs_pkg.sv
// constants for the access-list action combiner and statistics block
package acs_pkg;
  localparam int unsigned AXI_AW = 13;
  localparam int unsigned AXI_DW = 32;
  localparam int unsigned CNT_NUM = 1024;
  localparam int unsigned CNT_IW = 10;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned KEY_TYPES = 8;
  localparam int unsigned KEY_W = 3;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned EVT_W = 3;
  // register byte addresses
  localparam logic [AXI_AW-1:0] ADDR_CTRL = 13'h0000;
  localparam logic [AXI_AW-1:0] ADDR_KEYSEEN0 = 13'h0004;
  localparam logic [AXI_AW-1:0] ADDR_KEYSEEN1 = 13'h0008;
  localparam logic [AXI_AW-1:0] ADDR_INTSTAT = 13'h000c;
  localparam logic [AXI_AW-1:0] ADDR_INTCLR = 13'h0010;
  localparam logic [AXI_AW-1:0] ADDR_INTEN = 13'h0014;
  localparam logic [AXI_AW-1:0] ADDR_CNT_BASE = 13'h1000;
  // control field positions
  localparam int unsigned CTRL_IGR_MODE = 0;
  localparam int unsigned CTRL_EGR_MODE = 1;
  // event bit positions
  localparam int unsigned EVT_DONE = 0;
  localparam int unsigned EVT_DROP1 = 1;
  localparam int unsigned EVT_DROP2 = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  // port-mask modes
  typedef enum logic [MODE_W-1:0] {
    ACS_MASK_NONE = 3'h0,
    ACS_MASK_FILTER = 3'h1,
    ACS_MASK_POLICY = 3'h2,
    ACS_MASK_REPLACE_ALL = 3'h3,
    ACS_MASK_DEST_GROUP_REDIRECT = 3'h4,
    ACS_MASK_OR_DEST = 3'h5,
    ACS_MASK_STACK_FORWARD = 3'h6,
    ACS_MASK_RSVD = 3'h7
  } acs_mask_mode_e;
  // read channel states
  typedef enum logic [1:0] {
    ACS_RD_IDLE = 2'b01,
    ACS_RD_RESP = 2'b10
  } acs_rd_state_e;
endpackage : acs_pkg

// >>> rtl/acs_action_combiner.sv
// access-list action combiner with match counters and leg statistics
`timescale 1ns/1ps
module acs_action_combiner #(
  parameter int unsigned PORTS = 11,
  parameter int unsigned POL_W = 5,
  parameter int unsigned LOG_W = 8,
  parameter int unsigned MIR_W = 2,
  parameter int unsigned REW_W = 10,
  parameter int unsigned TAG_W = 16,
  parameter int unsigned MAC_W = 48,
  parameter int unsigned DOM_W = 2
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic actValid,
  input wire logic [1:0] actEn,
  input wire logic [1:0][acs_pkg::KEY_W-1:0] keyType,
  input wire logic [1:0] learningBlock,
  input wire logic [1:0] routingBlock,
  input wire logic [1:0] policerEnable,
  input wire logic [1:0][POL_W-1:0] policerIndex,
  input wire logic [1:0][LOG_W-1:0] ptpLoggingInterval,
  input wire logic [1:0][acs_pkg::MODE_W-1:0] maskMode,
  input wire logic [1:0][PORTS-1:0] portMask,
  input wire logic [PORTS-1:0] frameMask,
  input wire logic [1:0][MIR_W-1:0] mirrorTarget,
  input wire logic [1:0][REW_W-1:0] rewriteCommand,
  input wire logic [1:0] hopLimitPresetEnable,
  input wire logic [1:0] serviceTestSequenceEnable,
  input wire logic [1:0] l4PortReplaceEnable,
  input wire logic [1:0][TAG_W-1:0] matchTag,
  input wire logic [1:0][TAG_W-1:0] matchTagMask,
  input wire logic [1:0] pipeOverride,
  input wire logic [1:0][acs_pkg::CNT_IW-1:0] counterIndex,
  input wire logic [1:0] macExchangeEnable,
  input wire logic [1:0][acs_pkg::MODE_W-1:0] rewriteModeSelect,
  input wire logic [1:0][MAC_W-1:0] rewriteMacValue,
  input wire logic [1:0][DOM_W-1:0] timeDomainSelect,
  input wire logic [1:0] discard,
  input wire logic routed,
  output logic resValid,
  output logic resLearningBlock,
  output logic resRoutingBlock,
  output logic resPolicerEnable,
  output logic [POL_W-1:0] resPolicerIndex,
  output logic [LOG_W-1:0] resLoggingInterval,
  output logic [PORTS-1:0] resPortMask,
  output logic resMaskSticky,
  output logic [MIR_W-1:0] resMirrorTarget,
  output logic [REW_W-1:0] resRewriteCommand,
  output logic resHopLimitPreset,
  output logic resServiceTestSeq,
  output logic resL4Replace,
  output logic [TAG_W-1:0] resL4Tag,
  output logic [TAG_W-1:0] resL4TagMask,
  output logic [TAG_W-1:0] resMatchTag,
  output logic [1:0] resPipeOverride,
  output logic resMacExchange,
  output logic [acs_pkg::MODE_W-1:0] resRewriteModeA,
  output logic [MAC_W-1:0] resRewriteMacA,
  output logic [acs_pkg::MODE_W-1:0] resRewriteModeB,
  output logic [MAC_W-1:0] resRewriteMacB,
  output logic [DOM_W-1:0] resTimeDomain,
  output logic igrLegCount,
  output logic egrLegCount,
  output logic irq,
  input wire logic [acs_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [acs_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [acs_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [acs_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import acs_pkg::*;

  // new mask after one action; sticky modes end the chain
  function automatic logic [PORTS-1:0] mask_apply(
    input logic [MODE_W-1:0] mode,
    input logic [PORTS-1:0] cur,
    input logic [PORTS-1:0] act
  );
    case (mode)
      ACS_MASK_FILTER: mask_apply = cur & ~act;
      ACS_MASK_POLICY: mask_apply = cur & act;
      ACS_MASK_REPLACE_ALL: mask_apply = act;
      ACS_MASK_DEST_GROUP_REDIRECT: mask_apply = act;
      ACS_MASK_OR_DEST: mask_apply = cur | act;
      ACS_MASK_STACK_FORWARD: mask_apply = act;
      default: mask_apply = cur;
    endcase
  endfunction : mask_apply

  function automatic logic mask_sticky(input logic [MODE_W-1:0] mode);
    mask_sticky = (mode == ACS_MASK_REPLACE_ALL) ||
      (mode == ACS_MASK_DEST_GROUP_REDIRECT) ||
      (mode == ACS_MASK_STACK_FORWARD);
  endfunction : mask_sticky

  function automatic logic [TAG_W-1:0] tag_apply(
    input logic [TAG_W-1:0] cur,
    input logic [TAG_W-1:0] tag,
    input logic [TAG_W-1:0] msk
  );
    tag_apply = (cur & ~msk) | (tag & msk);
  endfunction : tag_apply

  // action combining, all combinational into one register stage
  wire logic go = ce & actValid;
  wire logic [1:0] en = actEn & {2{actValid}};
  wire logic use1 = en[1];
  wire logic useP1 = en[1] & policerEnable[1];
  wire logic sticky0 = en[0] & mask_sticky(maskMode[0]);
  wire logic [PORTS-1:0] mask0 =
    en[0] ? mask_apply(maskMode[0], frameMask, portMask[0]) : frameMask;
  wire logic [PORTS-1:0] mask1 = (en[1] && !sticky0) ?
    mask_apply(maskMode[1], mask0, portMask[1]) : mask0;
  wire logic sticky1 = sticky0 | (en[1] & mask_sticky(maskMode[1]));
  wire logic [TAG_W-1:0] tag0 =
    en[0] ? tag_apply('0, matchTag[0], matchTagMask[0]) : '0;
  wire logic [TAG_W-1:0] tag1 = en[1] ?
    tag_apply(tag0, matchTag[1], matchTagMask[1]) : tag0;
  wire logic l4Second = en[1] & l4PortReplaceEnable[1];
  wire logic l4First = en[0] & l4PortReplaceEnable[0];
  wire logic [MODE_W-1:0] rtMode0 = en[0] ? rewriteModeSelect[0] : '0;
  wire logic [MODE_W-1:0] rtMode1 = en[1] ? rewriteModeSelect[1] : '0;
  wire logic rtSame = (rtMode0 == rtMode1);
  wire logic [1:0] dropped = en & discard;
  logic [1:0] ctrlQ;
  wire logic igrCnt = routed &
    (dropped[0] ? ctrlQ[CTRL_IGR_MODE] : 1'b1);
  wire logic egrCnt = routed & !dropped[0] &
    (dropped[1] ? ctrlQ[CTRL_EGR_MODE] : 1'b1);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resValid <= 1'b0;
      igrLegCount <= 1'b0;
      egrLegCount <= 1'b0;
    end else if (ce) begin
      resValid <= actValid;
      igrLegCount <= actValid & igrCnt;
      egrLegCount <= actValid & egrCnt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resLearningBlock <= 1'b0;
      resRoutingBlock <= 1'b0;
      resPolicerEnable <= 1'b0;
      resPolicerIndex <= '0;
      resLoggingInterval <= '0;
      resPortMask <= '0;
      resMaskSticky <= 1'b0;
      resMirrorTarget <= '0;
      resRewriteCommand <= '0;
      resHopLimitPreset <= 1'b0;
      resServiceTestSeq <= 1'b0;
      resL4Replace <= 1'b0;
      resL4Tag <= '0;
      resL4TagMask <= '0;
      resMatchTag <= '0;
      resPipeOverride <= '0;
      resMacExchange <= 1'b0;
      resRewriteModeA <= '0;
      resRewriteMacA <= '0;
      resRewriteModeB <= '0;
      resRewriteMacB <= '0;
      resTimeDomain <= '0;
    end else if (go) begin
      resLearningBlock <= |(en & learningBlock);
      resRoutingBlock <= |(en & routingBlock);
      resPolicerEnable <= |(en & policerEnable);
      resMacExchange <= |(en & macExchangeEnable);
      resPolicerIndex <= useP1 ? policerIndex[1] :
        (en[0] ? policerIndex[0] : '0);
      resLoggingInterval <= (use1 && ptpLoggingInterval[1] != '0) ?
        ptpLoggingInterval[1] :
        (en[0] ? ptpLoggingInterval[0] : '0);
      resPortMask <= mask1;
      resMaskSticky <= sticky1;
      resMirrorTarget <= (use1 && mirrorTarget[1] != '0) ?
        mirrorTarget[1] : (en[0] ? mirrorTarget[0] : '0);
      // rewrite bits name functions, so union applies both
      resRewriteCommand <= (en[0] ? rewriteCommand[0] : '0) |
        (en[1] ? rewriteCommand[1] : '0);
      resHopLimitPreset <= |(en & hopLimitPresetEnable);
      resServiceTestSeq <= |(en & serviceTestSequenceEnable);
      resL4Replace <= l4Second | l4First;
      resL4Tag <= l4Second ? matchTag[1] :
        (l4First ? matchTag[0] : '0);
      resL4TagMask <= l4Second ? matchTagMask[1] :
        (l4First ? matchTagMask[0] : '0);
      resMatchTag <= tag1;
      resPipeOverride <= en & pipeOverride;
      // slot A carries the first mode only when it differs
      resRewriteModeA <= rtSame ? '0 : rtMode0;
      resRewriteMacA <= (rtSame || !en[0]) ? '0 : rewriteMacValue[0];
      resRewriteModeB <= rtSame ? (en[1] ? rtMode1 : rtMode0) : rtMode1;
      resRewriteMacB <= (rtSame && !en[1]) ?
        (en[0] ? rewriteMacValue[0] : '0) :
        (en[1] ? rewriteMacValue[1] : '0);
      resTimeDomain <= (use1 && timeDomainSelect[1] != '0) ?
        timeDomainSelect[1] :
        (en[0] ? timeDomainSelect[0] : '0);
    end
  end

  // axi4-lite write channel
  logic awHeldQ;
  logic wHeldQ;
  logic [AXI_AW-1:0] awAddrQ;
  logic [AXI_DW-1:0] wDataQ;
  logic [3:0] wStrbQ;
  assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
  assign s_axi_wready = !wHeldQ && !s_axi_bvalid;
  wire logic awFire = s_axi_awvalid & s_axi_awready;
  wire logic wFire = s_axi_wvalid & s_axi_wready;
  wire logic haveAw = awHeldQ | awFire;
  wire logic haveW = wHeldQ | wFire;
  wire logic [AXI_AW-1:0] wAddr = awHeldQ ? awAddrQ : s_axi_awaddr;
  wire logic [AXI_DW-1:0] wData = wHeldQ ? wDataQ : s_axi_wdata;
  wire logic [3:0] wStrb = wHeldQ ? wStrbQ : s_axi_wstrb;
  wire logic wrDo = ce & haveAw & haveW & !s_axi_bvalid;
  wire logic wrCnt = wAddr[AXI_AW-1:2] >= ADDR_CNT_BASE[AXI_AW-1:2];
  wire logic [CNT_IW-1:0] wrIdx = wAddr[CNT_IW+1:2];
  wire logic wrMapped = wrCnt || wAddr == ADDR_CTRL ||
    wAddr == ADDR_KEYSEEN0 || wAddr == ADDR_KEYSEEN1 ||
    wAddr == ADDR_INTCLR || wAddr == ADDR_INTEN ||
    wAddr == ADDR_INTSTAT;
  wire logic [AXI_DW-1:0] strbMask = {{8{wStrb[3]}}, {8{wStrb[2]}},
    {8{wStrb[1]}}, {8{wStrb[0]}}};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= '0;
      wStrbQ <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (awFire) begin
        awAddrQ <= s_axi_awaddr;
      end
      if (wFire) begin
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      awHeldQ <= haveAw & !wrDo;
      wHeldQ <= haveW & !wrDo;
      if (wrDo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control, key-type flags and interrupt registers
  logic [KEY_TYPES-1:0] keySeenQ [2];
  logic [EVT_W-1:0] intStatQ;
  logic [EVT_W-1:0] intEnQ;
  wire logic [EVT_W-1:0] evt = {EVT_W{go}} &
    {dropped[1], dropped[0], |en};
  assign irq = |(intStatQ & intEnQ);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrlQ <= '0;
      intEnQ <= '0;
      intStatQ <= '0;
    end else if (ce) begin
      if (wrDo && wAddr == ADDR_CTRL && wStrb[0]) begin
        ctrlQ <= wData[1:0];
      end
      if (wrDo && wAddr == ADDR_INTEN && wStrb[0]) begin
        intEnQ <= wData[EVT_W-1:0];
      end
      // a new event beats a clear in the same cycle
      intStatQ <= (intStatQ & ~((wrDo && wAddr == ADDR_INTCLR &&
        wStrb[0]) ? wData[EVT_W-1:0] : '0)) | evt;
    end
  end

  for (genvar l = 0; l < 2; l++) begin : g_key
    wire logic [AXI_AW-1:0] kAddr = l ? ADDR_KEYSEEN1 : ADDR_KEYSEEN0;
    wire logic [KEY_TYPES-1:0] kClr = (wrDo && wAddr == kAddr &&
      wStrb[0]) ? wData[KEY_TYPES-1:0] : '0;
    wire logic [KEY_TYPES-1:0] kSet = (go && en[l]) ?
      KEY_TYPES'(1) << keyType[l] : '0;
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        keySeenQ[l] <= '0;
      end else if (ce) begin
        keySeenQ[l] <= (keySeenQ[l] & ~kClr) | kSet;
      end
    end
  end

  // match counters; a same-cycle software write to an index wins
  logic [CNT_W-1:0] cntMem [CNT_NUM];
  wire logic sameIdx = counterIndex[0] == counterIndex[1];
  wire logic [CNT_W-1:0] cntInc0 = (sameIdx && en[1]) ?
    CNT_W'(2) : CNT_W'(1);
  wire logic [1:0] hit = {2{go}} & en;
  wire logic [CNT_W-1:0] swVal =
    (cntMem[wrIdx] & ~strbMask) | (wData & strbMask);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CNT_NUM; i++) begin
        cntMem[i] <= CNT_RESET;
      end
    end else if (ce) begin
      if (hit[0]) begin
        cntMem[counterIndex[0]] <= cntMem[counterIndex[0]] +
          cntInc0;
      end
      if (hit[1] && !(hit[0] && sameIdx)) begin
        cntMem[counterIndex[1]] <= cntMem[counterIndex[1]] +
          CNT_W'(1);
      end
      if (wrDo && wrCnt) begin
        cntMem[wrIdx] <= swVal;
      end
    end
  end

  // axi4-lite read channel
  acs_rd_state_e rdStateQ;
  assign s_axi_arready = (rdStateQ == ACS_RD_IDLE);
  assign s_axi_rvalid = (rdStateQ == ACS_RD_RESP);
  wire logic arFire = ce & s_axi_arvalid & s_axi_arready;
  wire logic rdCnt = s_axi_araddr[AXI_AW-1:2] >= ADDR_CNT_BASE[AXI_AW-1:2];
  logic [AXI_DW-1:0] rdVal;
  logic rdOk;

  always_comb begin
    rdVal = '0;
    rdOk = 1'b1;
    if (rdCnt) begin
      rdVal = cntMem[s_axi_araddr[CNT_IW+1:2]];
    end else begin
      case (s_axi_araddr)
        ADDR_CTRL: rdVal = AXI_DW'(ctrlQ);
        ADDR_KEYSEEN0: rdVal = AXI_DW'(keySeenQ[0]);
        ADDR_KEYSEEN1: rdVal = AXI_DW'(keySeenQ[1]);
        ADDR_INTSTAT: rdVal = AXI_DW'(intStatQ);
        ADDR_INTEN: rdVal = AXI_DW'(intEnQ);
        ADDR_INTCLR: rdVal = '0;
        default: rdOk = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdStateQ <= ACS_RD_IDLE;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      case (rdStateQ)
        ACS_RD_IDLE: begin
          if (arFire) begin
            rdStateQ <= ACS_RD_RESP;
            s_axi_rdata <= rdVal;
            s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
          end
        end
        ACS_RD_RESP: begin
          if (s_axi_rready) begin
            rdStateQ <= ACS_RD_IDLE;
          end
        end
        default: rdStateQ <= ACS_RD_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_sticky_learn: assert property (go && en[0] && learningBlock[0]
    |=> resLearningBlock) else $error("learning block lost");
  chk_policer_index: assert property (go && en[1] && !policerEnable[1]
    && en[0] |=> resPolicerIndex == $past(policerIndex[0]))
    else $error("policer index from wrong action");
  chk_log_zero: assert property (go && en == 2'b11
    && ptpLoggingInterval[1] == '0
    |=> resLoggingInterval == $past(ptpLoggingInterval[0]))
    else $error("zero logging interval overrode");
  chk_mask_sticky: assert property (go && en == 2'b11
    && maskMode[0] == ACS_MASK_REPLACE_ALL
    |=> resPortMask == $past(portMask[0]) && resMaskSticky)
    else $error("sticky mask modified");
  chk_mirror_zero: assert property (go && en == 2'b11
    && mirrorTarget[1] == '0
    |=> resMirrorTarget == $past(mirrorTarget[0]))
    else $error("zero mirror target overrode");
  chk_domain_sel: assert property (go && en[1]
    && timeDomainSelect[1] != '0
    |=> resTimeDomain == $past(timeDomainSelect[1]))
    else $error("time domain not from second");
  chk_pipe_each: assert property (go |=> resPipeOverride ==
    $past(actEn & pipeOverride)) else $error("override merged");
  chk_drop1_egr: assert property (go && en[0] && discard[0]
    |=> !egrLegCount) else $error("first drop counted egress");
  chk_drop2_igr: assert property (go && routed && dropped == 2'b10
    |=> igrLegCount) else $error("second drop missed ingress");
  chk_count_inc: assert property (go && en == 2'b01 && !wrDo
    |=> cntMem[$past(counterIndex[0])] ==
    $past(cntMem[counterIndex[0]]) + CNT_W'(1))
    else $error("counter not incremented");
  chk_key_set: assert property (go && en[0]
    |=> keySeenQ[0][$past(keyType[0])]) else $error("key flag");
  chk_axi_resp: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped");

  cov_both_actions: cover property (go && en == 2'b11);
  cov_same_counter: cover property (go && en == 2'b11 && sameIdx);
  cov_sticky_mask: cover property (go && sticky0 && en[1]);
  cov_irq_rise: cover property (!irq ##1 irq);
endmodule : acs_action_combiner

// >>> test/acs_lookup_model.sv
// lookup engine model: hands out random action pairs on request
`timescale 1ns/1ps
module acs_lookup_model (
  input wire logic clk_sys,
  input wire logic go,
  output logic actValid,
  output logic [305:0] act
);
  logic [305:0] a;
  // fields rescrambled every cycle, so stale values never look valid
  always begin
    a = 306'({$urandom, $urandom, $urandom, $urandom, $urandom,
      $urandom, $urandom, $urandom, $urandom, $urandom});
    a[305:304] = $urandom_range(3) != 0 ? 2'h3 : 2'($urandom);
    // indices kept to four so the bench can track every counter
    a[303:284] = {10'($urandom_range(3)), 10'($urandom_range(3))};
    if ($urandom_range(1) != 0) a[283:276] = 8'h00;
    actValid <= go === 1'b1;
    act <= a;
    @(posedge clk_sys);
  end
endmodule : acs_lookup_model

// >>> test/acs_action_combiner_test.sv
// self-checking bench for the access-list action combiner
`timescale 1ns/1ps
`define CHK(n, g, e) begin numChecks++; if ((g) !== (e)) begin \
  nErrors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module acs_action_combiner_test;
  import acs_pkg::*;
  typedef struct packed {
    logic v, ig, eg, l4c, ms;
    logic [3:0] st;
    logic [4:0] pi;
    logic [7:0] lg;
    logic [1:0] mi, td, hs, po;
    logic [9:0] rc;
    logic [10:0] pm;
    logic [15:0] tg;
    logic [31:0] l4t;
    logic [101:0] rw;
  } acs_exp_s;
  logic clk_sys, rst_b, ce, go, actValid, routed;
  logic [1:0] actEn, learningBlock, routingBlock, policerEnable, discard;
  logic [1:0] hopLimitPresetEnable, serviceTestSequenceEnable, ctrl;
  logic [1:0] l4PortReplaceEnable, pipeOverride, macExchangeEnable;
  logic [1:0][2:0] keyType, maskMode, rewriteModeSelect;
  logic [1:0][4:0] policerIndex;
  logic [1:0][7:0] ptpLoggingInterval;
  logic [1:0][10:0] portMask;
  logic [10:0] frameMask, resPortMask;
  logic [1:0][1:0] mirrorTarget, timeDomainSelect;
  logic [1:0][9:0] rewriteCommand, counterIndex;
  logic [1:0][15:0] matchTag, matchTagMask;
  logic [1:0][47:0] rewriteMacValue;
  logic resValid, resLearningBlock, resRoutingBlock, resPolicerEnable;
  logic resMaskSticky, resHopLimitPreset, resServiceTestSeq, resL4Replace;
  logic resMacExchange, igrLegCount, egrLegCount, irq;
  logic [4:0] resPolicerIndex;
  logic [7:0] resLoggingInterval;
  logic [1:0] resMirrorTarget, resPipeOverride, resTimeDomain;
  logic [9:0] resRewriteCommand;
  logic [15:0] resL4Tag, resL4TagMask, resMatchTag;
  logic [2:0] resRewriteModeA, resRewriteModeB;
  logic [47:0] resRewriteMacA, resRewriteMacB;
  logic [12:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [305:0] act;
  int nErrors, numChecks, cyc;
  logic [31:0] cnt [4];
  logic [7:0] seen [2];
  acs_exp_s qa[$];
  logic [33:0] qr[$];
  logic [1:0] qb[$];
  wire logic [3:0] gotSt = {resLearningBlock, resRoutingBlock,
    resPolicerEnable, resMacExchange};
  wire logic [101:0] gotRw = {resRewriteModeA, resRewriteMacA,
    resRewriteModeB, resRewriteMacB};
  wire logic [31:0] gotL4 = {resL4Tag, resL4TagMask};
  wire logic [1:0] gotHs = {resHopLimitPreset, resServiceTestSeq};
  assign {actEn, counterIndex, ptpLoggingInterval, keyType, learningBlock,
    routingBlock, policerEnable, policerIndex, maskMode, portMask, frameMask,
    mirrorTarget, rewriteCommand, hopLimitPresetEnable,
    serviceTestSequenceEnable, l4PortReplaceEnable, matchTag, matchTagMask,
    pipeOverride, macExchangeEnable, rewriteModeSelect, rewriteMacValue,
    timeDomainSelect, discard, routed} = act;
  acs_lookup_model i_acs_lookup_model (.clk_sys(clk_sys), .go(go),
    .actValid(actValid), .act(act));
  acs_action_combiner i_acs_action_combiner (.*);
  always #5 clk_sys = ~clk_sys;
  function automatic logic [10:0] mstep(logic [2:0] m, logic [10:0] c, p);
    case (m)
      3'h1: return c & ~p;
      3'h2: return c & p;
      3'h3, 3'h4, 3'h6: return p;
      3'h5: return c | p;
      default: return c;
    endcase
  endfunction : mstep
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(logic [12:0] a, logic [31:0] d, logic [1:0] r);
    qb.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(logic [12:0] a, logic [33:0] e);
    qr.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  // notes the expected combined result of each pair taken
  always @(posedge clk_sys) begin
    acs_exp_s e;
    if (rst_b && actValid) begin
      e.v = actEn == 2'h3;
      e.st = {|learningBlock, |routingBlock, |policerEnable,
        |macExchangeEnable};
      e.pi = policerEnable[1] ? policerIndex[1] : policerIndex[0];
      e.lg = ptpLoggingInterval[ptpLoggingInterval[1] != 0];
      e.mi = mirrorTarget[mirrorTarget[1] != 0];
      e.td = timeDomainSelect[timeDomainSelect[1] != 0];
      e.rc = rewriteCommand[0] | rewriteCommand[1];
      e.hs = {|hopLimitPresetEnable, |serviceTestSequenceEnable};
      e.pm = mstep(maskMode[0], frameMask, portMask[0]);
      if (!(maskMode[0] inside {3'h3, 3'h4, 3'h6}))
        e.pm = mstep(maskMode[1], e.pm, portMask[1]);
      e.tg = (matchTag[0] & matchTagMask[0] & ~matchTagMask[1]) |
        (matchTag[1] & matchTagMask[1]);
      e.po = pipeOverride;
      e.rw = {rewriteModeSelect[0] == rewriteModeSelect[1] ? 51'h0 :
        {rewriteModeSelect[0], rewriteMacValue[0]}, rewriteModeSelect[1],
        rewriteMacValue[1]};
      e.ms = (maskMode[0] inside {3'h3, 3'h4, 3'h6}) |
        (maskMode[1] inside {3'h3, 3'h4, 3'h6});
      e.l4t = l4PortReplaceEnable[1] ? {matchTag[1], matchTagMask[1]} :
        l4PortReplaceEnable[0] ? {matchTag[0], matchTagMask[0]} : 32'h0;
      e.l4c = |l4PortReplaceEnable;
      e.ig = routed & (!discard[0] | ctrl[0]);
      e.eg = routed & !discard[0] & (!discard[1] | ctrl[1]);
      qa.push_back(e);
      for (int i = 0; i < 2; i++) if (actEn[i]) begin
        cnt[counterIndex[i][1:0]] += 32'h1;
        seen[i][keyType[i]] = 1'b1;
      end
    end
  end
  // compares each result with both actions enabled against the oldest note
  always @(posedge clk_sys) begin
    acs_exp_s x;
    logic [33:0] y;
    logic [1:0] z;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      y = qr.pop_front();
      `CHK("rdata", {s_axi_rresp, s_axi_rdata}, y)
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      z = qb.pop_front();
      `CHK("bresp", s_axi_bresp, z)
    end
    if (resValid === 1'b1) begin
      x = qa.pop_front();
      if (x.v) begin
        `CHK("igr", igrLegCount, x.ig)
        `CHK("egr", egrLegCount, x.eg)
        `CHK("sticky", gotSt, x.st)
        `CHK("polidx", resPolicerIndex, x.pi)
        `CHK("logint", resLoggingInterval, x.lg)
        `CHK("mask", resPortMask, x.pm)
        `CHK("mirror", resMirrorTarget, x.mi)
        `CHK("rewcmd", resRewriteCommand, x.rc)
        `CHK("hopseq", gotHs, x.hs)
        `CHK("rwmode", gotRw, x.rw)
        `CHK("l4", resL4Replace, x.l4c)
        `CHK("l4tag", gotL4, x.l4t)
        `CHK("msticky", resMaskSticky, x.ms)
        `CHK("tag", resMatchTag, x.tg)
        `CHK("pipe", resPipeOverride, x.po)
        `CHK("domain", resTimeDomain, x.td)
      end
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      nErrors++;
      tally_and_finish();
    end
  end
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    go = 1'b0;
    ctrl = 2'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 28'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    cnt = '{default: 32'h0};
    seen = '{default: 8'h0};
    void'($urandom(34325));
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      ctrl = 2'(p);
      wr(ADDR_CTRL, 32'(p), RESP_OKAY);
      go <= 1'b1;
      repeat (50) @(posedge clk_sys);
      go <= 1'b0;
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 4; i++)
        rd(ADDR_CNT_BASE + 13'(4 * i), {RESP_OKAY, cnt[i]});
      // counter 0 cleared, the others preset; all but counter 3 then counted onward
      cnt[p] = p == 0 ? 32'h0 : $urandom;
      wr(ADDR_CNT_BASE + 13'(4 * p), cnt[p], RESP_OKAY);
    end
    for (int i = 0; i < 2; i++) begin
      rd(ADDR_KEYSEEN0 + 13'(4 * i), {RESP_OKAY, 24'h0, seen[i]});
      wr(ADDR_KEYSEEN0 + 13'(4 * i), 32'hff, RESP_OKAY);
      rd(ADDR_KEYSEEN0 + 13'(4 * i), {RESP_OKAY, 32'h0});
    end
    rd(ADDR_INTSTAT, {RESP_OKAY, 32'h7});
    wr(ADDR_INTEN, 32'h2, RESP_OKAY);
    `CHK("irq on", irq, 1'b1)
    wr(ADDR_INTCLR, 32'h2, RESP_OKAY);
    `CHK("irq masked", irq, 1'b0)
    rd(ADDR_INTSTAT, {RESP_OKAY, 32'h5});
    rd(13'h0800, {RESP_SLVERR, 32'h0});
    wr(13'h0800, 32'h1, RESP_SLVERR);
    `CHK("pending", qa.size(), 0)
    tally_and_finish();
  end
endmodule : acs_action_combiner_test
